// file: hw/supply_monitor_flag_logic.sv
// Operation
// - Two bits choose digital supply trip point
// - Two bits choose analog supply trip point
// - Bit 7 reads digital comparator state
// - Bit 6 reads analog comparator state
// - Either comparator low sets flag bit 5
// - Flag set by a low supply clears after 250 ms good supplies
// - Software clear refused while comparator low
// - Bit 0 enables or disables the monitor
// - Interrupt forwarded only when irq_enable_priority_two is high
// - Comparator glitches are filtered out
`timescale 1ns/1ns
`include "supply_monitor_map.svh"

module supply_monitor_flag_logic #(
  parameter int DELAY_TICKS = `CLEAR_DELAY_TICKS,
  parameter int FILTER_CYC  = `GLITCH_FILTER_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire supply_monitor_pkg::sfr_req_t sfr_req,
  output logic [7:0]                        sfr_rdata,
  input  wire logic                         digital_supply_ok_raw,
  input  wire logic                         analog_supply_ok_raw,
  input  wire logic                         ref_tick_raw,
  input  wire logic                         irq_enable_priority_two,
  output logic [1:0]                        digital_trip_sel,
  output logic [1:0]                        analog_trip_sel,
  output logic                              supply_monitor_on,
  output logic                              low_supply_irq
);

  localparam int DW = $clog2(DELAY_TICKS + 1);

  logic                             rst_meta_b;
  logic                             rst_sync_b;
  logic                             digital_supply_ok;
  logic                             analog_supply_ok;
  logic                             tick_a;
  logic                             tick_b;
  logic                             tick_d;
  logic                             tick_pulse;
  logic                             irq_en_a;
  logic                             irq_en_b;
  supply_monitor_pkg::monitor_cfg_t cfg;
  supply_monitor_pkg::monitor_cfg_t next_cfg;
  logic                             low_supply_flag;
  logic                             next_flag;
  supply_monitor_pkg::flag_state_t  state;
  supply_monitor_pkg::flag_state_t  next_state;
  logic [DW-1:0]                    delay_cnt;
  logic [DW-1:0]                    next_delay_cnt;
  logic [7:0]                       next_rdata;
  logic                             next_irq;
  logic                             both_ok;
  logic                             reg_wr;
  logic                             reg_rd;
  logic [1:0]                       supply_ok_raw;
  logic [1:0]                       supply_ok;

  // Reset takes hold at once but is released in step with the clock.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  assign supply_ok_raw = {digital_supply_ok_raw, analog_supply_ok_raw};

  // Bit 1 carries the digital supply and bit 0 the analog supply.
  generate
    for (genvar i = 0; i < 2; i++) begin : g_supply_filter
      glitch_filter #(.FILTER_CYC(FILTER_CYC)) glitch_filter_inst (
        .clk        (clk),
        .rst_sync_b (rst_sync_b),
        .raw_async  (supply_ok_raw[i]),
        .filtered   (supply_ok[i])
      );
    end
  endgenerate

  assign digital_supply_ok = supply_ok[1];
  assign analog_supply_ok  = supply_ok[0];

  // The reference tick and interrupt enable come from other domains.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tick_a   <= 1'b0;
      tick_b   <= 1'b0;
      tick_d   <= 1'b0;
      irq_en_a <= 1'b0;
      irq_en_b <= 1'b0;
    end else begin
      tick_a   <= ref_tick_raw;
      tick_b   <= tick_a;
      tick_d   <= tick_b;
      irq_en_a <= irq_enable_priority_two;
      irq_en_b <= irq_en_a;
    end
  end

  // Both strobes decode the same single register address.
  function automatic logic sfr_hit(input logic [7:0] addr);
    return addr == `SMC_ADDR;
  endfunction : sfr_hit

  // A rising reference edge makes one clock-wide tick pulse.
  assign tick_pulse = tick_b & ~tick_d;
  assign reg_wr     = sfr_req.wr && sfr_hit(sfr_req.addr);
  assign reg_rd     = sfr_req.rd && sfr_hit(sfr_req.addr);
  assign both_ok    = digital_supply_ok & analog_supply_ok;

  // Only the trip and enable fields live here; the flag has its own logic.
  always_comb begin
    next_cfg = cfg;
    if (reg_wr) begin
      next_cfg.digital_trip = supply_monitor_pkg::trip_sel_t'(
        {sfr_req.wdata[`SMC_DIG_TRIP_HI], sfr_req.wdata[`SMC_DIG_TRIP_LO]});
      next_cfg.analog_trip = supply_monitor_pkg::trip_sel_t'(
        {sfr_req.wdata[`SMC_ANA_TRIP_HI], sfr_req.wdata[`SMC_ANA_TRIP_LO]});
      next_cfg.supply_monitor_on = sfr_req.wdata[`SMC_ON_BIT];
    end
  end

  // Flag state: hardware set wins over any software clear.
  always_comb begin
    next_flag      = low_supply_flag;
    next_state     = state;
    next_delay_cnt = delay_cnt;
    // While the monitor is off only software moves the flag.
    if (!cfg.supply_monitor_on) begin
      next_state     = supply_monitor_pkg::ST_IDLE;
      next_delay_cnt = '0;
      if (reg_wr) begin
        next_flag = sfr_req.wdata[`SMC_LOW_FLAG_BIT];
      end
    end else if (!both_ok) begin
      next_flag      = 1'b1;
      next_state     = supply_monitor_pkg::ST_LOW;
      next_delay_cnt = '0;
    end else begin
      unique case (state)
        supply_monitor_pkg::ST_IDLE: begin
          // A flag that software sets here waits for software to clear it.
        end
        supply_monitor_pkg::ST_LOW: begin
          next_state     = supply_monitor_pkg::ST_DELAY;
          next_delay_cnt = '0;
        end
        supply_monitor_pkg::ST_DELAY: begin
          if (tick_pulse) begin
            if (delay_cnt == DW'(DELAY_TICKS - 1)) begin
              next_flag      = 1'b0;
              next_state     = supply_monitor_pkg::ST_IDLE;
              next_delay_cnt = '0;
            end else begin
              next_delay_cnt = delay_cnt + DW'(1);
            end
          end
        end
        default: begin
          next_state = supply_monitor_pkg::ST_IDLE;
        end
      endcase
      // A software write of 1 wins over the timer clear in the same cycle.
      if (reg_wr) begin
        next_flag = sfr_req.wdata[`SMC_LOW_FLAG_BIT];
      end
    end
  end

  // Read data is captured on a read and stands until the next read.
  always_comb begin
    next_rdata = sfr_rdata;
    if (reg_rd) begin
      next_rdata = {digital_supply_ok, analog_supply_ok, low_supply_flag,
                    cfg.digital_trip, cfg.analog_trip, cfg.supply_monitor_on};
    end
    next_irq = low_supply_flag & irq_en_b;
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      // The reset value leaves the monitor off with the lowest trip points.
      cfg             <= supply_monitor_pkg::monitor_cfg_t'(5'(`SMC_RESET));
      low_supply_flag <= 1'(`SMC_RESET >> `SMC_LOW_FLAG_BIT);
      state           <= supply_monitor_pkg::ST_IDLE;
      delay_cnt       <= '0;
      sfr_rdata       <= 8'h00;
      low_supply_irq  <= 1'b0;
    end else begin
      cfg             <= next_cfg;
      low_supply_flag <= next_flag;
      state           <= next_state;
      delay_cnt       <= next_delay_cnt;
      sfr_rdata       <= next_rdata;
      low_supply_irq  <= next_irq;
    end
  end

  // The comparator controls are registered copies of the next configuration.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      digital_trip_sel  <= 2'h3;
      analog_trip_sel   <= 2'h3;
      supply_monitor_on <= 1'b0;
    end else begin
      digital_trip_sel  <= next_cfg.digital_trip;
      analog_trip_sel   <= next_cfg.analog_trip;
      supply_monitor_on <= next_cfg.supply_monitor_on;
    end
  end

endmodule : supply_monitor_flag_logic

// file: hw/supply_monitor_map.svh
`ifndef SUPPLY_MONITOR_MAP_SVH
`define SUPPLY_MONITOR_MAP_SVH

`define SMC_ADDR          8'hDF
`define SMC_RESET         8'hDE
`define SMC_DIG_OK_BIT    7
`define SMC_ANA_OK_BIT    6
`define SMC_LOW_FLAG_BIT  5
`define SMC_DIG_TRIP_HI   4
`define SMC_DIG_TRIP_LO   3
`define SMC_ANA_TRIP_HI   2
`define SMC_ANA_TRIP_LO   1
`define SMC_ON_BIT        0
`define CLEAR_DELAY_MS    250
`define REF_CLK_HZ        32768
`define CLEAR_DELAY_TICKS ((`CLEAR_DELAY_MS * `REF_CLK_HZ) / 1000)
`define GLITCH_FILTER_CYC 8

`endif

// file: hw/supply_monitor_pkg.sv
package supply_monitor_pkg;

  typedef enum logic [1:0] {
    TRIP_4V63 = 2'h0,
    TRIP_3V08 = 2'h1,
    TRIP_2V93 = 2'h2,
    TRIP_2V63 = 2'h3
  } trip_sel_t;

  typedef struct packed {
    trip_sel_t digital_trip;
    trip_sel_t analog_trip;
    logic      supply_monitor_on;
  } monitor_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_LOW   = 2'h1,
    ST_DELAY = 2'h3
  } flag_state_t;

endpackage : supply_monitor_pkg

// file: hw/glitch_filter.sv
`timescale 1ns/1ns
`include "supply_monitor_map.svh"

module glitch_filter #(
  parameter int FILTER_CYC = `GLITCH_FILTER_CYC
) (
  input  wire logic clk,
  input  wire logic rst_sync_b,
  input  wire logic raw_async,
  output logic      filtered
);

  localparam int CW = $clog2(FILTER_CYC + 1);

  logic          sync_a;
  logic          sync_b;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_filtered;

  // Two-flop synchroniser; only the second stage is read by logic.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else begin
      sync_a <= raw_async;
      sync_b <= sync_a;
    end
  end

  // The output follows only after the input held steady for FILTER_CYC cycles.
  always_comb begin
    next_count    = count;
    next_filtered = filtered;
    if (sync_b == filtered) begin
      next_count = '0;
    end else if (count == CW'(FILTER_CYC - 1)) begin
      next_count    = '0;
      next_filtered = sync_b;
    end else begin
      next_count = count + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      count    <= '0;
      filtered <= 1'b1;
    end else begin
      count    <= next_count;
      filtered <= next_filtered;
    end
  end

endmodule : glitch_filter

// file: tb/supply_monitor_flag_logic_asserts.sv
`timescale 1ns/1ns
module supply_monitor_flag_logic_asserts #(
  parameter int DELAY_TICKS = 4,
  parameter int FILTER_CYC  = 2
) (
  input wire logic                         clk,
  input wire logic                         rst_b,
  input wire supply_monitor_pkg::sfr_req_t sfr_req,
  input wire logic [7:0]                   sfr_rdata,
  input wire logic                         digital_supply_ok_raw,
  input wire logic                         analog_supply_ok_raw,
  input wire logic                         ref_tick_raw,
  input wire logic                         irq_enable_priority_two,
  input wire logic [1:0]                   digital_trip_sel,
  input wire logic [1:0]                   analog_trip_sel,
  input wire logic                         supply_monitor_on,
  input wire logic                         low_supply_irq
);
  logic hit_wr;
  logic hit_rd;
  assign hit_wr = sfr_req.wr && sfr_req.addr == 8'hDF;
  assign hit_rd = sfr_req.rd && sfr_req.addr == 8'hDF;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence dig_low_held;
    (!digital_supply_ok_raw && supply_monitor_on && irq_enable_priority_two)[*8];
  endsequence
  sequence ana_low_held;
    (!analog_supply_ok_raw && supply_monitor_on && irq_enable_priority_two)[*8];
  endsequence
  AST_DIG_TRIP: assert property (hit_wr |=> digital_trip_sel == $past(sfr_req.wdata[4:3]))
    else $error("digital trip select not taken");
  AST_ANA_TRIP: assert property (hit_wr |=> analog_trip_sel == $past(sfr_req.wdata[2:1]))
    else $error("analog trip select not taken");
  AST_ON_BIT: assert property (hit_wr |=> supply_monitor_on == $past(sfr_req.wdata[0]))
    else $error("monitor enable not taken");
  AST_CFG_HOLD: assert property (!hit_wr |=> $stable({digital_trip_sel, analog_trip_sel}))
    else $error("trip selects moved without a write");
  AST_RD_HOLD: assert property (!hit_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  AST_RD_CFG: assert property (hit_rd && !sfr_req.wr |=>
    sfr_rdata[4:0] == $past({digital_trip_sel, analog_trip_sel, supply_monitor_on}))
    else $error("read data does not show the configuration");
  AST_DIG_LOW: assert property (dig_low_held |-> ##[0:8] low_supply_irq)
    else $error("digital supply low did not raise the interrupt");
  AST_ANA_LOW: assert property (ana_low_held |-> ##[0:8] low_supply_irq)
    else $error("analog supply low did not raise the interrupt");
  AST_IRQ_GATE: assert property (low_supply_irq |-> $past(irq_enable_priority_two, 2) ||
    $past(irq_enable_priority_two, 3) || $past(irq_enable_priority_two, 4))
    else $error("interrupt raised while disabled");
endmodule : supply_monitor_flag_logic_asserts

bind supply_monitor_flag_logic supply_monitor_flag_logic_asserts #(
  .DELAY_TICKS(DELAY_TICKS), .FILTER_CYC(FILTER_CYC)) supply_monitor_flag_logic_asserts_inst (
  .clk(clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .digital_supply_ok_raw(digital_supply_ok_raw), .analog_supply_ok_raw(analog_supply_ok_raw),
  .ref_tick_raw(ref_tick_raw), .irq_enable_priority_two(irq_enable_priority_two),
  .digital_trip_sel(digital_trip_sel), .analog_trip_sel(analog_trip_sel),
  .supply_monitor_on(supply_monitor_on), .low_supply_irq(low_supply_irq));

// file: tb/supply_comparator_model.sv
`timescale 1ns/1ns
module supply_comparator_model #(
  parameter int TICK_HALF_NS = 2000
) (
  input  wire logic [1:0]  digital_trip_sel,
  input  wire logic [1:0]  analog_trip_sel,
  input  wire logic [12:0] dig_mv,
  input  wire logic [12:0] ana_mv,
  output logic             digital_supply_ok_raw,
  output logic             analog_supply_ok_raw,
  output logic             ref_tick_raw
);
  function automatic logic [12:0] trip_mv(input logic [1:0] s);
    return s == 2'h0 ? 13'h1216 : s == 2'h1 ? 13'h0C08 : s == 2'h2 ? 13'h0B72 : 13'h0A46;
  endfunction : trip_mv
  assign digital_supply_ok_raw = dig_mv > trip_mv(digital_trip_sel);
  assign analog_supply_ok_raw  = ana_mv > trip_mv(analog_trip_sel);
  // The reference runs free, with a phase unrelated to the core clock.
  initial begin
    ref_tick_raw = 1'b0;
    #37;
    forever #(TICK_HALF_NS) ref_tick_raw = ~ref_tick_raw;
  end
endmodule : supply_comparator_model

// file: tb/supply_monitor_flag_logic_tb.sv
`timescale 1ns/1ns
module supply_monitor_flag_logic_tb;
  logic                         clk;
  logic                         rst_b;
  supply_monitor_pkg::sfr_req_t sfr_req;
  logic [7:0]                   sfr_rdata;
  logic                         d_ok;
  logic                         a_ok;
  logic                         tick;
  logic                         irq_en;
  logic [1:0]                   d_sel;
  logic [1:0]                   a_sel;
  logic                         mon_on;
  logic                         irq;
  logic [12:0]                  d_mv;
  logic [12:0]                  a_mv;
  logic [31:0]                  seed;
  int                           num_errors;
  int                           checked;
  int                           cycles;

  supply_monitor_flag_logic #(.DELAY_TICKS(4), .FILTER_CYC(2)) supply_monitor_flag_logic_inst (
    .clk(clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .digital_supply_ok_raw(d_ok), .analog_supply_ok_raw(a_ok), .ref_tick_raw(tick),
    .irq_enable_priority_two(irq_en), .digital_trip_sel(d_sel), .analog_trip_sel(a_sel),
    .supply_monitor_on(mon_on), .low_supply_irq(irq));
  supply_comparator_model supply_comparator_model_inst (
    .digital_trip_sel(d_sel), .analog_trip_sel(a_sel), .dig_mv(d_mv), .ana_mv(a_mv),
    .digital_supply_ok_raw(d_ok), .analog_supply_ok_raw(a_ok), .ref_tick_raw(tick));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [12:0] thr(input logic [1:0] s);
    return s == 2'h0 ? 13'h1216 : s == 2'h1 ? 13'h0C08 : s == 2'h2 ? 13'h0B72 : 13'h0A46;
  endfunction : thr
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xorshift
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk);
    sfr_req = '{addr: a, wdata: d, wr: w, rd: !w};
    @(negedge clk);
    sfr_req.wr = 1'b0;
    sfr_req.rd = 1'b0;
  endtask : access
  task automatic rd_chk(input string what, input logic [7:0] exp);
    access(8'hDF, 8'h00, 1'b0);
    chk(what, exp, sfr_rdata);
  endtask : rd_chk
  task automatic close_out;
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    rst_b = 1'b0;
    sfr_req = '0;
    irq_en = 1'b0;
    d_mv = 13'h1388;
    a_mv = 13'h1388;
    seed = 32'h5C02;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    rd_chk("reset value", 8'hDE);
    for (int i = 0; i < 16; i++) begin
      seed = xorshift(seed);
      access(8'hDF, {3'h0, seed[3:0], 1'b1}, 1'b1);
      d_mv = thr(seed[3:2]) + {9'h0, seed[11:8]} + 13'h1;
      a_mv = thr(seed[1:0]) + {9'h0, seed[15:12]} + 13'h1;
      repeat (8) @(negedge clk);
      rd_chk("config", {3'b110, seed[3:0], 1'b1});
    end
    access(8'hDE, 8'hFF, 1'b1);
    rd_chk("unmapped", {3'b110, seed[3:0], 1'b1});
    access(8'hDF, 8'h01, 1'b1);
    d_mv = 13'h1388;
    a_mv = 13'h1200;
    irq_en = 1'b1;
    repeat (10) @(negedge clk);
    rd_chk("analog low", 8'hA1);
    chk("irq", 8'h01, {7'h0, irq});
    access(8'hDF, 8'h01, 1'b1);
    rd_chk("clear refused", 8'hA1);
    a_mv = 13'h1388;
    repeat (10) @(negedge clk);
    rd_chk("delay pending", 8'hE1);
    repeat (48) @(negedge clk);
    d_mv = 13'h1200;
    repeat (10) @(negedge clk);
    d_mv = 13'h1388;
    repeat (108) @(negedge clk);
    rd_chk("restart", 8'hE1);
    repeat (200) @(negedge clk);
    rd_chk("auto clear", 8'hC1);
    d_mv = 13'h1200;
    @(negedge clk);
    d_mv = 13'h1388;
    repeat (10) @(negedge clk);
    rd_chk("glitch", 8'hC1);
    irq_en = 1'b0;
    access(8'hDF, 8'h21, 1'b1);
    repeat (6) @(negedge clk);
    chk("irq masked", 8'h00, {7'h0, irq});
    irq_en = 1'b1;
    repeat (6) @(negedge clk);
    chk("irq enabled", 8'h01, {7'h0, irq});
    access(8'hDF, 8'h01, 1'b1);
    rd_chk("software clear", 8'hC1);
    access(8'hDF, 8'h00, 1'b1);
    a_mv = 13'h1200;
    repeat (12) @(negedge clk);
    rd_chk("monitor off", 8'h80);
    close_out();
  end
endmodule : supply_monitor_flag_logic_tb
